// file: design/ssx_defs.vh
// Constants shared by the serial link controller and its transmit FIFO
`ifndef SSX_DEFS_VH
`define SSX_DEFS_VH

// ----------------------------------------------------------------
// Word and counter widths
// ----------------------------------------------------------------
`define SSX_WORD_W 16
`define SSX_FIFO_DEPTH 32
`define SSX_FIFO_AW 5

// ----------------------------------------------------------------
// Word length selection
// ----------------------------------------------------------------
`define SSX_BITS_DEFAULT 5'h08
`define SSX_BITS_MAX 5'h10
`define SSX_BITS_CODE_MAX 4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Serial clock may run at most one eighth of mclk
`define SSX_CLK_RATIO 8
// Shortest master half period in mclk cycles: ratio / 2
`define SSX_MIN_HALF 7'h04

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSX_RST_WORD 16'h0000
`define SSX_RST_CNT 5'h00
`define SSX_RST_DIV 7'h00
`define SSX_RST_HCNT 6'h00
// Pin samples {mosi, miso, select_n, sck}; select idles inactive
`define SSX_RST_SYNC 4'h2

`endif

// file: design/ssx_fifo.v
// Synchronous FIFO holding transmit words until a data write claims them
`default_nettype none

module ssx_fifo #(
    parameter W = 16,
    parameter D = 32,
    parameter AW = 5
) (
    input wire mclk_i,
    input wire nrst_i,
    input wire in_valid_i,
    output reg in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);

    localparam [AW:0] FULL = D[AW:0];
    localparam [AW:0] ONE = {{AW{1'b0}}, 1'b1};

    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wptr;
    reg [AW-1:0] rptr;
    reg [AW:0] count;
    reg [AW:0] next_count;

    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rptr];

    always @* begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + ONE;
        end else if (pop & ~push) begin
            next_count = count - ONE;
        end
    end

    always @(posedge mclk_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end

    // Ready is registered so the top sees a clean level
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wptr <= {AW{1'b0}};
            rptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready_o <= 1'b0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
            count <= next_count;
            in_ready_o <= (next_count != FULL);
        end
    end

endmodule

`default_nettype wire

// file: design/ssx_core.v
// Master/slave serial link controller with exception flags and pin control
// Functional notes
// - Done flag clears on data access after a status read saw it set.
// - Slave sets done right after the last sampling edge.
// - Completion while done is set drops the word and flags overrun.
// - Data write from transfer start to status read is dropped, flags collision.
// - Select active while master flags mode fault, drops drivers, becomes slave.
// - Select inactive mid slave transfer drops data, goes idle, flags abort.
// - Serial clock toggles only during transfers, otherwise idle level or floating.
// - Master never drives the select line.
// - Selected slave drives master-in; master samples it; unselected slave floats it.
// - Master drives master-out; slave only reads it.
// - Master data write starts transfer; done set after last clock cycle.
// - Phase zero spans select; phase one spans first edge to last sample.
// - Phase zero samples first edge, phase one second; polarity sets idle level.
// - With interrupt enable, done or mode fault raises the interrupt.
`include "ssx_defs.vh"
`default_nettype none

module ssx_core (
    input wire mclk_i,
    input wire nrst_i,
    input wire master_mode_i,
    input wire clock_phase_select_i,
    input wire clock_polarity_select_i,
    input wire lsb_first_i,
    input wire irq_enable_bit_i,
    input wire bits_enable_i,
    input wire [3:0] bits_count_i,
    input wire [7:0] clk_div_i,
    input wire tx_valid_i,
    input wire [15:0] tx_data_i,
    output wire tx_ready_o,
    input wire data_wr_i,
    input wire data_rd_i,
    input wire status_rd_i,
    output reg [15:0] rd_data_o,
    output reg transfer_done_flag_o,
    output reg read_overrun_flag_o,
    output reg write_collision_flag_o,
    output reg mode_fault_flag_o,
    output reg slave_abort_flag_o,
    output reg master_active_o,
    output reg busy_o,
    output reg irq_o,
    input wire serial_clock_pin_i,
    output reg serial_clock_pin_o,
    output reg serial_clock_pin_oe_o,
    input wire slave_select_pin_n_i,
    input wire master_in_line_i,
    output reg master_in_line_o,
    output reg master_in_line_oe_o,
    input wire master_out_line_i,
    output reg master_out_line_o,
    output reg master_out_line_oe_o
);

    // ----------------------------------------------------------------
    // Master sequencer states
    // ----------------------------------------------------------------
    localparam M_IDLE = 1'b0;
    localparam M_RUN = 1'b1;

    reg [3:0] sync1;
    reg [3:0] sync2;
    reg mode_lock;
    reg sck_prev;
    reg sel_prev;
    reg xfer;
    reg [4:0] samp_cnt;
    reg [4:0] tx_idx;
    reg [15:0] rx_sh;
    reg [15:0] tx_sh;
    reg mstate;
    reg m_done;
    reg [6:0] divc;
    reg [5:0] hcnt;
    reg wc_win;
    reg st_seen;

    wire fifo_valid;
    wire [15:0] fifo_data;

    // ----------------------------------------------------------------
    // Word length and clock events
    // ----------------------------------------------------------------
    wire [4:0] nbits = !bits_enable_i ? `SSX_BITS_DEFAULT :
                       (bits_count_i == `SSX_BITS_CODE_MAX) ? `SSX_BITS_MAX :
                       bits_count_i[3] ? {1'b0, bits_count_i} : `SSX_BITS_DEFAULT;
    wire clock_phase_select = clock_phase_select_i;
    wire clock_polarity_select = clock_polarity_select_i;
    wire selected = ~sync2[1];
    wire sck_lvl = master_active_o ? serial_clock_pin_o : sync2[0];
    wire sck_edge = sck_lvl ^ sck_prev;
    wire lead = sck_edge & (sck_lvl ^ clock_polarity_select);
    wire trail = sck_edge & ~(sck_lvl ^ clock_polarity_select);
    wire samp_e = clock_phase_select ? trail : lead;
    wire drv_e = clock_phase_select ? lead : trail;
    // master samples master-in, slave samples master-out
    wire din = master_active_o ? sync2[2] : sync2[3];

    // ----------------------------------------------------------------
    // Transfer framing
    // ----------------------------------------------------------------
    wire m_run = (mstate == M_RUN);
    // slave start at select (phase 0) or first edge
    wire s_begin = ~master_active_o & selected & ~xfer & ((~clock_phase_select & ~sel_prev) | lead);
    wire s_abort = ~master_active_o & xfer & ~selected;
    wire run = master_active_o ? (m_run | m_done) : ((xfer | s_begin) & selected);
    wire busy_w = master_active_o ? (m_run | m_done) : xfer;
    wire do_samp = run & samp_e;
    wire [4:0] samp_nxt = samp_cnt + 5'h01;
    wire last_samp = do_samp & (samp_nxt == nbits);
    wire [15:0] rx_next = !do_samp ? rx_sh :
                          lsb_first_i ? {din, rx_sh[15:1]} : {rx_sh[14:0], din};
    wire [4:0] rx_align = `SSX_BITS_MAX - nbits;
    wire [15:0] rx_word = lsb_first_i ? (rx_next >> rx_align) : rx_next;

    wire [6:0] half = (clk_div_i[7:1] < `SSX_MIN_HALF) ? `SSX_MIN_HALF : clk_div_i[7:1];
    wire half_tick = m_run & (divc == half - 7'h01);
    wire [5:0] m_last = {nbits, 1'b0} - 6'h01;
    wire m_end = half_tick & (hcnt == m_last);
    // slave done right after last sample; master after last cycle
    wire complete = master_active_o ? m_done : last_samp;

    wire mfault = master_active_o & selected;

    // ----------------------------------------------------------------
    // Software access decode
    // ----------------------------------------------------------------
    // writes inside the window are lost
    wire wr_col = data_wr_i & (wc_win | busy_w);
    wire wr_ok = data_wr_i & ~wr_col;
    // master write starts transfer at once
    wire m_start = wr_ok & master_active_o & ~mfault;
    wire done_clr = (data_rd_i | data_wr_i) & st_seen;
    wire stat_clr = status_rd_i;

    wire [4:0] tsel = lsb_first_i ? tx_idx : (nbits - 5'h01 - tx_idx);
    wire tbit = tx_sh[tsel[3:0]];
    wire restart = s_begin | s_abort | complete | m_start;

    ssx_fifo #(
        .W(`SSX_WORD_W),
        .D(`SSX_FIFO_DEPTH),
        .AW(`SSX_FIFO_AW)
    ) u_txq (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i(tx_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(wr_ok),
        .out_data_o(fifo_data)
    );

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // slow remote clock lets two flops plus edge detect keep up
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1 <= `SSX_RST_SYNC;
            sync2 <= `SSX_RST_SYNC;
        end else begin
            sync1 <= {master_out_line_i, master_in_line_i, slave_select_pin_n_i,
                      serial_clock_pin_i};
            sync2 <= sync1;
        end
    end

    // ----------------------------------------------------------------
    // Mode, framing and shift logic
    // ----------------------------------------------------------------
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            master_active_o <= 1'b0;
            mode_lock <= 1'b0;
            sck_prev <= 1'b0;
            sel_prev <= 1'b0;
            xfer <= 1'b0;
            samp_cnt <= `SSX_RST_CNT;
            tx_idx <= `SSX_RST_CNT;
            rx_sh <= `SSX_RST_WORD;
            tx_sh <= `SSX_RST_WORD;
            mstate <= M_IDLE;
            m_done <= 1'b0;
            divc <= `SSX_RST_DIV;
            hcnt <= `SSX_RST_HCNT;
            serial_clock_pin_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            // fault locks slave mode until software drops master mode
            mode_lock <= mfault | (mode_lock & master_mode_i);
            master_active_o <= master_mode_i & ~mode_lock & ~mfault;
            sck_prev <= sck_lvl;
            sel_prev <= selected;
            busy_o <= busy_w;
            m_done <= m_end & ~mfault;

            if (s_abort | last_samp | master_active_o) begin
                xfer <= 1'b0;
            end else if (s_begin) begin
                xfer <= 1'b1;
            end

            if (restart) begin
                samp_cnt <= `SSX_RST_CNT;
                tx_idx <= `SSX_RST_CNT;
                rx_sh <= `SSX_RST_WORD;
                if (do_samp & ~complete & ~s_abort) begin
                    samp_cnt <= 5'h01;
                    rx_sh <= rx_next;
                end
            end else begin
                if (do_samp) begin
                    samp_cnt <= samp_nxt;
                    rx_sh <= rx_next;
                end
                if (run & drv_e & (samp_cnt != `SSX_RST_CNT)) begin
                    tx_idx <= tx_idx + 5'h01;
                end
            end

            // slave load blocked during transfers by the collision check
            if (wr_ok) begin
                tx_sh <= fifo_valid ? fifo_data : `SSX_RST_WORD;
            end

            // master clock idles at polarity level, toggles only in run
            case (mstate)
                M_IDLE: begin
                    serial_clock_pin_o <= clock_polarity_select;
                    divc <= `SSX_RST_DIV;
                    hcnt <= `SSX_RST_HCNT;
                    if (m_start) begin
                        mstate <= M_RUN;
                    end
                end
                M_RUN: begin
                    if (mfault) begin
                        mstate <= M_IDLE;
                    end else if (half_tick) begin
                        divc <= `SSX_RST_DIV;
                        serial_clock_pin_o <= ~serial_clock_pin_o;
                        hcnt <= hcnt + 6'h01;
                        if (m_end) begin
                            mstate <= M_IDLE;
                        end
                    end else begin
                        divc <= divc + 7'h01;
                    end
                end
                default: begin
                    mstate <= M_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Status flags and receive buffer
    // ----------------------------------------------------------------
    // Every flag: a set in the same cycle as its clear wins
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_o <= `SSX_RST_WORD;
            transfer_done_flag_o <= 1'b0;
            read_overrun_flag_o <= 1'b0;
            write_collision_flag_o <= 1'b0;
            mode_fault_flag_o <= 1'b0;
            slave_abort_flag_o <= 1'b0;
            wc_win <= 1'b0;
            st_seen <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            // full buffer keeps the old word
            if (complete & ~transfer_done_flag_o) begin
                rd_data_o <= rx_word;
            end
            // done held until status read then data access
            transfer_done_flag_o <= complete | (transfer_done_flag_o & ~done_clr);
            st_seen <= (status_rd_i & transfer_done_flag_o) | (st_seen & ~done_clr);
            // exception flags report once per status read
            // overrun on completion with done still set
            read_overrun_flag_o <= (complete & transfer_done_flag_o) |
                                   (read_overrun_flag_o & ~stat_clr);
            write_collision_flag_o <= wr_col | (write_collision_flag_o & ~stat_clr);
            mode_fault_flag_o <= mfault | (mode_fault_flag_o & ~stat_clr);
            slave_abort_flag_o <= s_abort | (slave_abort_flag_o & ~stat_clr);
            // window opens at start, closes on status read seeing done
            if (s_begin | m_start) begin
                wc_win <= 1'b1;
            end else if (s_abort | (status_rd_i & transfer_done_flag_o)) begin
                wc_win <= 1'b0;
            end
            // interrupt follows done or fault when enabled
            irq_o <= irq_enable_bit_i & (transfer_done_flag_o | mode_fault_flag_o);
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // Enables lag mode by one cycle; fault drops them on the next edge
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_clock_pin_oe_o <= 1'b0;
            master_out_line_o <= 1'b0;
            master_out_line_oe_o <= 1'b0;
            master_in_line_o <= 1'b0;
            master_in_line_oe_o <= 1'b0;
        end else begin
            // select line is input only; remote slaves use other outputs
            // sck driven only by a master
            serial_clock_pin_oe_o <= master_active_o & ~mfault;
            // master drives master-out, slave never does
            master_out_line_o <= tbit;
            master_out_line_oe_o <= master_active_o & ~mfault;
            master_in_line_o <= tbit;
            // relies on select held low through the transaction
            master_in_line_oe_o <= ~master_active_o & ~mfault & selected;
        end
    end

endmodule

`default_nettype wire

// file: testbench/ssx_core_properties.sv
// Port-level checks on the serial link controller
`default_nettype none
module ssx_core_properties (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic data_wr_i,
    input wire logic data_rd_i,
    input wire logic status_rd_i,
    input wire logic irq_enable_bit_i,
    input wire logic slave_select_pin_n_i,
    input wire logic [15:0] rd_data_o,
    input wire logic transfer_done_flag_o,
    input wire logic read_overrun_flag_o,
    input wire logic write_collision_flag_o,
    input wire logic slave_abort_flag_o,
    input wire logic mode_fault_flag_o,
    input wire logic master_active_o,
    input wire logic busy_o,
    input wire logic irq_o,
    input wire logic serial_clock_pin_oe_o,
    input wire logic master_in_line_oe_o,
    input wire logic master_out_line_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // -------------------------------------------------
    // Flags and pin drivers
    // -------------------------------------------------
    a_sck_master_only: assert property (
        !master_active_o [*2] |-> !serial_clock_pin_oe_o) else $error("sck driven as slave");
    a_mosi_master_only: assert property (
        !master_active_o [*2] |-> !master_out_line_oe_o) else $error("mosi driven as slave");
    a_miso_not_master: assert property (
        master_active_o [*2] |-> !master_in_line_oe_o) else $error("miso driven as master");
    a_miso_needs_select: assert property (
        slave_select_pin_n_i [*4] |-> !master_in_line_oe_o) else $error("miso driven unselected");
    a_fault_drops: assert property (
        $rose(mode_fault_flag_o) |-> ##[0:2] (!master_active_o && !master_out_line_oe_o))
        else $error("fault kept master");
    a_done_clear: assert property (
        $fell(transfer_done_flag_o) |-> $past(data_rd_i) || $past(data_wr_i))
        else $error("done cleared without data access");
    a_overrun_keeps: assert property (
        $rose(read_overrun_flag_o) |-> $stable(rd_data_o) && transfer_done_flag_o)
        else $error("overrun replaced word");
    a_collision_set: assert property (
        data_wr_i && busy_o |=> write_collision_flag_o) else $error("no collision");
    a_status_clears: assert property (
        status_rd_i && !data_wr_i && !busy_o && slave_select_pin_n_i |=>
        !read_overrun_flag_o && !write_collision_flag_o && !slave_abort_flag_o)
        else $error("exception flags kept");
    a_irq_raise: assert property (
        (transfer_done_flag_o && irq_enable_bit_i) [*2] |-> irq_o) else $error("irq missing");
    a_irq_mask: assert property (
        !irq_enable_bit_i [*2] |-> !irq_o) else $error("irq while masked");
endmodule
bind ssx_core ssx_core_properties u_props (.mclk_i, .nrst_i, .data_wr_i, .data_rd_i,
    .status_rd_i, .irq_enable_bit_i, .slave_select_pin_n_i, .rd_data_o, .transfer_done_flag_o,
    .read_overrun_flag_o, .write_collision_flag_o, .slave_abort_flag_o, .mode_fault_flag_o,
    .master_active_o, .busy_o, .irq_o, .serial_clock_pin_oe_o, .master_in_line_oe_o,
    .master_out_line_oe_o);
`default_nettype wire

// file: testbench/ssx_remote_master.sv
// Behavioural remote master, phase 0 and polarity 0
`default_nettype none
module ssx_remote_master (
    input wire logic miso_i,
    output logic sck_o,
    output logic sel_n_o,
    output logic mosi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock still and select inactive between frames
    initial begin
        sck_o = 1'h0;
        sel_n_o = 1'h1;
        mosi_o = 1'h0;
    end
    // 80 ns half period, select low over frame, sample on rise
    task automatic run(input logic [15:0] word, input int nb, input int stop,
                       output logic [15:0] got);
        int i;
        got = 16'h0000;
        sel_n_o = 1'h0;
        mosi_o = word[nb-1];
        #80;
        for (i = 0; i < stop; i++) begin
            sck_o = 1'h1;
            got = {got[14:0], miso_i};
            #80;
            sck_o = 1'h0;
            if (i < nb - 1) mosi_o = word[nb-2-i];
            #80;
        end
        sel_n_o = 1'h1;
        // Released line must not look held
        mosi_o = ~mosi_o;
        #80;
    endtask
endmodule
`default_nettype wire

// file: testbench/ssx_core_bench.sv
// Self-checking bench for the serial link controller
`default_nettype none
module ssx_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] ST = 3'h4;
    localparam logic [2:0] RD = 3'h2;
    localparam logic [2:0] WR = 3'h1;
    logic mclk_i = 1'h0;
    logic nrst_i = 1'h0;
    logic master_mode_i = 1'h0;
    logic irq_enable_bit_i = 1'h0;
    logic clock_polarity_select_i = 1'h0;
    logic bits_enable_i = 1'h0;
    logic tx_valid_i = 1'h0;
    logic data_wr_i = 1'h0;
    logic data_rd_i = 1'h0;
    logic status_rd_i = 1'h0;
    logic [7:0] clk_div_i = 8'h08;
    logic [15:0] tx_data_i = 16'h0000;
    logic [15:0] rd_data_o;
    logic [15:0] got;
    logic [15:0] mosi_cap;
    logic tx_ready_o, transfer_done_flag_o, read_overrun_flag_o, write_collision_flag_o;
    logic mode_fault_flag_o, slave_abort_flag_o, master_active_o, busy_o, irq_o;
    logic serial_clock_pin_o, serial_clock_pin_oe_o, master_in_line_o, master_in_line_oe_o;
    logic master_out_line_o, master_out_line_oe_o, rm_sck, rm_mosi, slave_select_pin_n_i;
    logic serial_clock_pin_i, master_in_line_i, master_out_line_i;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int sck_edges = 0;
    assign serial_clock_pin_i = serial_clock_pin_oe_o ? serial_clock_pin_o : rm_sck;
    assign master_out_line_i = master_out_line_oe_o ? master_out_line_o : rm_mosi;
    // Undriven line shows a moving value, not the last one
    assign master_in_line_i = master_in_line_oe_o ? master_in_line_o : ~master_in_line_o;
    ssx_remote_master rm (.miso_i(master_in_line_i), .sck_o(rm_sck),
        .sel_n_o(slave_select_pin_n_i), .mosi_o(rm_mosi));
    ssx_core dut (.mclk_i, .nrst_i, .master_mode_i, .clock_phase_select_i(1'h0),
        .clock_polarity_select_i, .lsb_first_i(1'h0), .irq_enable_bit_i,
        .bits_enable_i, .bits_count_i(4'h0), .clk_div_i, .tx_valid_i, .tx_data_i,
        .tx_ready_o, .data_wr_i, .data_rd_i, .status_rd_i, .rd_data_o, .transfer_done_flag_o,
        .read_overrun_flag_o, .write_collision_flag_o, .mode_fault_flag_o, .slave_abort_flag_o,
        .master_active_o, .busy_o, .irq_o, .serial_clock_pin_i, .serial_clock_pin_o,
        .serial_clock_pin_oe_o, .slave_select_pin_n_i, .master_in_line_i, .master_in_line_o,
        .master_in_line_oe_o, .master_out_line_i, .master_out_line_o, .master_out_line_oe_o);
    // -------------------------------------------------
    // Clock, timeout and shared tasks
    // -------------------------------------------------
    initial forever #5 mclk_i = ~mclk_i;
    always @(posedge serial_clock_pin_i) sck_edges++;
    // Master runs polarity 1, phase 0: falling edge is the sampling edge
    always @(negedge serial_clock_pin_i) mosi_cap = {mosi_cap[14:0], master_out_line_o};
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: timeout", $time);
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic g, input logic e, input string m);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic strobe(input logic [2:0] s);
        @(negedge mclk_i);
        {status_rd_i, data_rd_i, data_wr_i} = s;
        @(negedge mclk_i);
        {status_rd_i, data_rd_i, data_wr_i} = 3'h0;
    endtask
    task automatic wait_done(input int lim);
        for (int n = 0; n < lim && transfer_done_flag_o !== 1'h1; n++) @(negedge mclk_i);
    endtask
    // -------------------------------------------------
    // Scenarios
    // -------------------------------------------------
    task automatic t_fifo();
        chk_bit(transfer_done_flag_o, 1'h0, "done after reset");
        for (int i = 0; i < 32; i++) begin
            @(negedge mclk_i);
            tx_valid_i = 1'h1;
            tx_data_i = 16'h003c + 16'(i);
        end
        @(negedge mclk_i);
        tx_valid_i = 1'h0;
        chk_bit(tx_ready_o, 1'h0, "fifo full");
        strobe(WR);
        chk_bit(tx_ready_o, 1'h1, "fifo pop");
    endtask
    task automatic t_slave();
        rm.run(16'h00a5, 8, 8, got);
        wait_done(20);
        chk_bit(transfer_done_flag_o, 1'h1, "slave done");
        chk_word(rd_data_o, 16'h00a5, "slave rx");
        chk_word(got, 16'h003c, "slave tx");
        strobe(RD);
        chk_bit(transfer_done_flag_o, 1'h1, "done kept");
    endtask
    task automatic t_overrun();
        fork
            rm.run(16'h005a, 8, 8, got);
            begin
                repeat (60) @(negedge mclk_i);
                strobe(WR);
            end
        join
        chk_bit(write_collision_flag_o, 1'h1, "collision");
        chk_bit(read_overrun_flag_o, 1'h1, "overrun");
        chk_word(rd_data_o, 16'h00a5, "overrun word");
        strobe(ST);
        chk_bit(read_overrun_flag_o, 1'h0, "overrun clear");
        chk_bit(write_collision_flag_o, 1'h0, "collision clear");
        strobe(RD);
        chk_bit(transfer_done_flag_o, 1'h0, "done clear");
    endtask
    task automatic t_abort();
        rm.run(16'h00ff, 8, 4, got);
        chk_bit(slave_abort_flag_o, 1'h1, "abort");
        chk_bit(transfer_done_flag_o, 1'h0, "abort no done");
        chk_word(rd_data_o, 16'h00a5, "abort word");
        strobe(ST);
        chk_bit(slave_abort_flag_o, 1'h0, "abort clear");
    endtask
    task automatic t_master();
        @(negedge mclk_i);
        irq_enable_bit_i = 1'h1;
        master_mode_i = 1'h1;
        clock_polarity_select_i = 1'h1;
        bits_enable_i = 1'h1;
        for (int n = 0; n < 20 && master_active_o !== 1'h1; n++) @(negedge mclk_i);
        // Let the clock enable settle before counting edges
        repeat (2) @(negedge mclk_i);
        chk_bit(serial_clock_pin_o, 1'h1, "sck idle level");
        sck_edges = 0;
        strobe(WR);
        wait_done(200);
        @(negedge mclk_i);
        chk_bit(transfer_done_flag_o, 1'h1, "master done");
        chk_bit(irq_o, 1'h1, "irq done");
        chk_word(16'(sck_edges), 16'h0010, "sck pulses");
        chk_word(mosi_cap, 16'h003d, "master tx");
        chk_bit(serial_clock_pin_o, 1'h1, "sck rests");
        strobe(ST);
        strobe(RD);
    endtask
    task automatic t_fault();
        @(negedge mclk_i);
        rm.sel_n_o = 1'h0;
        repeat (8) @(negedge mclk_i);
        chk_bit(mode_fault_flag_o, 1'h1, "fault");
        chk_bit(master_active_o, 1'h0, "fault slave");
        chk_bit(master_out_line_oe_o, 1'h0, "fault drivers");
        chk_bit(irq_o, 1'h1, "irq fault");
        master_mode_i = 1'h0;
        rm.sel_n_o = 1'h1;
        repeat (4) @(negedge mclk_i);
        strobe(ST);
        @(negedge mclk_i);
        chk_bit(mode_fault_flag_o, 1'h0, "fault clear");
        chk_bit(irq_o, 1'h0, "irq clear");
    endtask
    initial begin
        repeat (4) @(negedge mclk_i);
        nrst_i = 1'h1;
        repeat (3) @(negedge mclk_i);
        t_fifo();
        t_slave();
        t_overrun();
        t_abort();
        t_master();
        t_fault();
        test_done();
    end
endmodule
`default_nettype wire
